// ### logic/scd_device.sv
`timescale 1ns/10ps
module scd_device (
	input wire logic core_clk,
	input wire logic rst,
	scd_if.device lnk,
	output logic mem_reset_pulse,
	output logic wake_pulse
);
	import scd_pkg::*;

	typedef enum logic [2:0] {
		PH_OP, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_DONE, PH_IDLE
	} scd_ph_t;

	// ----------------------------------------
	// Frame state, cleared while deselected
	// ----------------------------------------
	logic frame_rst;
	scd_ph_t ph_ff, nxt_ph;
	logic [6:0] cnt_ff, nxt_cnt;
	logic [63:0] sh_ff, nxt_sh;
	logic [7:0] op_ff, nxt_op;
	logic [31:0] addr_ff, nxt_addr;
	logic [63:0] out_ff, nxt_out;
	logic [63:0] data_in;
	logic [7:0] op_now;
	scd_cmd_t ci, ci_new, ci_sel;
	logic ev_op, ev_addr, ev_din;
	logic [63:0] rd_word;

	// ----------------------------------------
	// Device registers
	// ----------------------------------------
	logic [7:0] cfg2_ff [CFG2_DEPTH];
	logic [7:0] nxt_cfg2 [CFG2_DEPTH];
	logic [SPB_DEPTH-1:0] spb_ff, nxt_spb;
	logic [7:0] sec_ff, nxt_sec;
	logic [31:0] fbr_ff, nxt_fbr;
	logic [63:0] pass_ff, nxt_pass;
	logic armed_ff, nxt_armed;
	logic rst_tgl_ff, nxt_rst_tgl;
	logic wake_tgl_ff, nxt_wake_tgl;

	// ----------------------------------------
	// Output stage and core side
	// ----------------------------------------
	logic miso_ff, nxt_miso;
	logic oe_ff, nxt_oe;
	logic [1:0] tgl_s;
	logic [1:0] tgl_prev_ff, nxt_tgl_prev;
	logic mrst_ff, nxt_mrst;
	logic wake_ff, nxt_wake;

	assign frame_rst = rst | lnk.cs_n;

	function automatic scd_ph_t after_ph(input scd_ph_t cur,
		input scd_cmd_t c);
		if (cur == PH_OP && c.addr_bits != 7'd0)
			return PH_ADDR;
		if (cur != PH_DUMMY && c.dummy_bits != 7'd0)
			return PH_DUMMY;
		if (c.din_bits != 7'd0)
			return PH_DIN;
		if (c.dout_bits != 7'd0)
			return PH_DOUT;
		return PH_DONE;
	endfunction

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	always_comb begin
		data_in = {sh_ff[62:0], lnk.mosi}; // RULE_19
		op_now = data_in[7:0];
		ci = scd_cmd_info(op_ff);
		ci_new = scd_cmd_info(op_now);
		nxt_ph = ph_ff;
		nxt_cnt = cnt_ff + 7'd1;
		nxt_sh = data_in;
		nxt_op = op_ff;
		nxt_addr = addr_ff;
		nxt_out = out_ff;
		ev_op = 1'b0;
		ev_addr = 1'b0;
		ev_din = 1'b0;
		case (ph_ff)
			PH_OP: begin
				if (cnt_ff == OPCODE_BITS - 7'd1) begin // RULE_20
					nxt_op = op_now;
					ev_op = 1'b1;
					nxt_cnt = 7'd0;
					if (!ci_new.valid)
						nxt_ph = PH_IDLE; // RULE_18
					else
						nxt_ph = after_ph(PH_OP, ci_new);
				end
			end
			PH_ADDR: begin
				if (cnt_ff == ci.addr_bits - 7'd1) begin
					nxt_addr = data_in[31:0];
					nxt_cnt = 7'd0;
					if (ci.zero_addr && data_in[31:0] != 32'h0) begin
						nxt_ph = PH_IDLE; // RULE_12 RULE_13 RULE_18
					end else begin
						ev_addr = 1'b1;
						nxt_ph = after_ph(PH_ADDR, ci);
					end
				end
			end
			PH_DUMMY: begin
				if (cnt_ff == ci.dummy_bits - 7'd1) begin // RULE_12
					nxt_cnt = 7'd0;
					nxt_ph = after_ph(PH_DUMMY, ci);
				end
			end
			PH_DIN: begin
				if (cnt_ff == ci.din_bits - 7'd1) begin // RULE_21
					ev_din = 1'b1;
					nxt_ph = PH_DONE;
				end
			end
			PH_DOUT: begin
				nxt_out = {out_ff[62:0], 1'b0};
				if (cnt_ff == ci.dout_bits - 7'd1)
					nxt_ph = PH_DONE;
			end
			default: begin
				nxt_cnt = cnt_ff;
				nxt_sh = sh_ff;
			end
		endcase
		ci_sel = scd_cmd_info(nxt_op);
		case (nxt_op)
			STATUS_READ_CMD: rd_word = {56'h0, STATUS_RST}; // RULE_01
			CONFIG_READ_CMD: rd_word = {56'h0, CONFIG_RST}; // RULE_02
			SECOND_CONFIG_READ_CMD: // RULE_03
				rd_word = {56'h0, cfg2_ff[nxt_addr[1:0]]};
			SECURITY_READ_CMD: rd_word = {56'h0, sec_ff}; // RULE_05
			FASTBOOT_READ_CMD: rd_word = {32'h0, fbr_ff}; // RULE_07
			PERSISTENT_PROT_READ_CMD: // RULE_10
				rd_word = {56'h0, {8{spb_ff[nxt_addr[2:0]]}}};
			PASSWORD_READ_CMD: rd_word = pass_ff; // RULE_12
			default: rd_word = 64'h0;
		endcase
		if (nxt_ph == PH_DOUT && ph_ff != PH_DOUT)
			nxt_out = rd_word << (7'd64 - ci_sel.dout_bits);
	end

	always_ff @(posedge lnk.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			ph_ff <= PH_OP;
			cnt_ff <= 7'd0;
			sh_ff <= 64'h0;
			op_ff <= 8'h00;
			addr_ff <= 32'h0;
			out_ff <= 64'h0;
		end else begin
			ph_ff <= nxt_ph;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			op_ff <= nxt_op;
			addr_ff <= nxt_addr;
			out_ff <= nxt_out;
		end
	end

	// ----------------------------------------
	// Register updates on completed commands
	// ----------------------------------------
	always_comb begin
		nxt_cfg2 = cfg2_ff;
		nxt_spb = spb_ff;
		nxt_sec = sec_ff;
		nxt_fbr = fbr_ff;
		nxt_pass = pass_ff;
		nxt_armed = armed_ff;
		nxt_rst_tgl = rst_tgl_ff;
		nxt_wake_tgl = wake_tgl_ff;
		if (ev_op) begin
			nxt_armed = (op_now == RESET_ARM_CMD); // RULE_16
			if (op_now == MEM_RESET_CMD && armed_ff)
				nxt_rst_tgl = ~rst_tgl_ff; // RULE_16
			if (op_now == WAKE_FROM_POWERDOWN_CMD)
				nxt_wake_tgl = ~wake_tgl_ff; // RULE_14
			if (op_now == SECURITY_WRITE_CMD)
				nxt_sec[SEC_LOCK_BIT] = 1'b1; // RULE_06
			if (op_now == FASTBOOT_ERASE_CMD)
				nxt_fbr = FBR_RST; // RULE_09
		end
		if (ev_addr && op_ff == PERSISTENT_PROT_PROGRAM_CMD)
			nxt_spb[nxt_addr[2:0]] = 1'b1; // RULE_11
		if (ev_din) begin
			case (op_ff)
				SECOND_CONFIG_WRITE_CMD: // RULE_04
					nxt_cfg2[addr_ff[1:0]] = data_in[7:0];
				FASTBOOT_WRITE_CMD: nxt_fbr = data_in[31:0]; // RULE_08
				PASSWORD_WRITE_CMD: nxt_pass = data_in; // RULE_13
				PASSWORD_UNLOCK_CMD: // RULE_13
					nxt_sec[SEC_UNLOCK_BIT] = (data_in == pass_ff);
				default: nxt_pass = pass_ff;
			endcase
		end
	end

	always_ff @(posedge lnk.sclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CFG2_DEPTH; i++)
				cfg2_ff[i] <= CFG2_RST;
			spb_ff <= '0;
			sec_ff <= SEC_RST;
			fbr_ff <= FBR_RST;
			pass_ff <= PASS_RST;
			armed_ff <= 1'b0;
			rst_tgl_ff <= 1'b0;
			wake_tgl_ff <= 1'b0;
		end else begin
			cfg2_ff <= nxt_cfg2;
			spb_ff <= nxt_spb;
			sec_ff <= nxt_sec;
			fbr_ff <= nxt_fbr;
			pass_ff <= nxt_pass;
			armed_ff <= nxt_armed;
			rst_tgl_ff <= nxt_rst_tgl;
			wake_tgl_ff <= nxt_wake_tgl;
		end
	end

	// ----------------------------------------
	// Serial output on falling edge
	// ----------------------------------------
	always_comb begin
		nxt_miso = out_ff[63]; // RULE_19
		nxt_oe = (ph_ff == PH_DOUT); // RULE_18
	end

	always_ff @(negedge lnk.sclk or posedge frame_rst) begin
		if (frame_rst) begin
			miso_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			miso_ff <= nxt_miso;
			oe_ff <= nxt_oe;
		end
	end

	assign lnk.miso_o = miso_ff;
	assign lnk.miso_oe = oe_ff;

	// ----------------------------------------
	// Event crossing to core clock
	// ----------------------------------------
	scd_sync #(.W(2)) u_sync (
		.clk(core_clk),
		.rst(rst),
		.d({rst_tgl_ff, wake_tgl_ff}),
		.q(tgl_s)
	);

	always_comb begin
		nxt_tgl_prev = tgl_s;
		nxt_mrst = tgl_s[1] ^ tgl_prev_ff[1];
		nxt_wake = tgl_s[0] ^ tgl_prev_ff[0];
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tgl_prev_ff <= 2'b00;
			mrst_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			tgl_prev_ff <= nxt_tgl_prev;
			mrst_ff <= nxt_mrst;
			wake_ff <= nxt_wake;
		end
	end

	assign mem_reset_pulse = mrst_ff;
	assign wake_pulse = wake_ff;
endmodule // scd_device

// ### shared/scd_pkg.sv
// What this block does
// RULE_01: Status read 05, no address, one byte
// RULE_02: Config read 15, no address, one byte
// RULE_03: Config2 read 71, four address bytes, one byte
// RULE_04: Config2 write 72, four address, one byte
// RULE_05: Security read 2B, no address, no dummy
// RULE_06: Security write 2F, nothing follows opcode
// RULE_07: Fast-boot read 16, one to four bytes
// RULE_08: Fast-boot write 17, exactly four bytes
// RULE_09: Fast-boot erase 18, nothing follows opcode
// RULE_10: Protection status read E2, four address, byte
// RULE_11: Protection program E3, four address, no data
// RULE_12: Password read 27, zero address, 8 dummy, 8 bytes
// RULE_13: Password write 28, unlock 29, eight bytes
// RULE_14: Wake from power down AB, opcode only
// RULE_15: Host sends reset arm before memory reset
// RULE_16: Memory reset ignored unless directly after arm
// RULE_17: Host sends only defined opcodes and addresses
// RULE_18: Bad sequence: standby, output off until frame
// RULE_19: Sample on rising, shift on falling edge
// RULE_20: Phases back to back, first byte opcode
// RULE_21: Early chip select rise changes nothing
package scd_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] CONFIG_READ_CMD = 8'h15;
	localparam logic [7:0] SECOND_CONFIG_READ_CMD = 8'h71;
	localparam logic [7:0] SECOND_CONFIG_WRITE_CMD = 8'h72;
	localparam logic [7:0] SECURITY_READ_CMD = 8'h2b;
	localparam logic [7:0] SECURITY_WRITE_CMD = 8'h2f;
	localparam logic [7:0] FASTBOOT_READ_CMD = 8'h16;
	localparam logic [7:0] FASTBOOT_WRITE_CMD = 8'h17;
	localparam logic [7:0] FASTBOOT_ERASE_CMD = 8'h18;
	localparam logic [7:0] PERSISTENT_PROT_READ_CMD = 8'he2;
	localparam logic [7:0] PERSISTENT_PROT_PROGRAM_CMD = 8'he3;
	localparam logic [7:0] PASSWORD_READ_CMD = 8'h27;
	localparam logic [7:0] PASSWORD_WRITE_CMD = 8'h28;
	localparam logic [7:0] PASSWORD_UNLOCK_CMD = 8'h29;
	localparam logic [7:0] WAKE_FROM_POWERDOWN_CMD = 8'hab;
	localparam logic [7:0] RESET_ARM_CMD = 8'h66;
	localparam logic [7:0] MEM_RESET_CMD = 8'h99;

	// ----------------------------------------
	// Phase lengths in bits
	// ----------------------------------------
	localparam logic [6:0] OPCODE_BITS = 7'd8;
	localparam logic [6:0] ADDR_BITS = 7'd32;
	localparam logic [6:0] BYTE_BITS = 7'd8;
	localparam logic [6:0] PASS_DUMMY_BITS = 7'd8;
	localparam logic [6:0] FBR_BITS = 7'd32;
	localparam logic [6:0] PASS_BITS = 7'd64;

	// ----------------------------------------
	// Reset values, fields, sizes, timing
	// ----------------------------------------
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [7:0] SEC_RST = 8'h00;
	localparam logic [31:0] FBR_RST = 32'hffff_ffff;
	localparam logic [63:0] PASS_RST = 64'hffff_ffff_ffff_ffff;
	localparam int SEC_LOCK_BIT = 1;
	localparam int SEC_UNLOCK_BIT = 7;
	localparam int CFG2_DEPTH = 4;
	localparam int SPB_DEPTH = 8;
	localparam logic [2:0] SCLK_HALF_CYC = 3'd4;

	typedef struct packed {
		logic valid;
		logic zero_addr;
		logic [6:0] addr_bits;
		logic [6:0] dummy_bits;
		logic [6:0] din_bits;
		logic [6:0] dout_bits;
	} scd_cmd_t;

	// ----------------------------------------
	// Command layout lookup
	// ----------------------------------------
	function automatic scd_cmd_t scd_cmd_info(input logic [7:0] op);
		scd_cmd_t c;
		c = '0;
		c.valid = 1'b1;
		case (op)
			STATUS_READ_CMD: c.dout_bits = BYTE_BITS; // RULE_01
			CONFIG_READ_CMD: c.dout_bits = BYTE_BITS; // RULE_02
			SECOND_CONFIG_READ_CMD: begin // RULE_03
				c.addr_bits = ADDR_BITS;
				c.dout_bits = BYTE_BITS;
			end
			SECOND_CONFIG_WRITE_CMD: begin // RULE_04
				c.addr_bits = ADDR_BITS;
				c.din_bits = BYTE_BITS;
			end
			SECURITY_READ_CMD: c.dout_bits = BYTE_BITS; // RULE_05
			SECURITY_WRITE_CMD: c.valid = 1'b1; // RULE_06
			FASTBOOT_READ_CMD: c.dout_bits = FBR_BITS; // RULE_07
			FASTBOOT_WRITE_CMD: c.din_bits = FBR_BITS; // RULE_08
			FASTBOOT_ERASE_CMD: c.valid = 1'b1; // RULE_09
			PERSISTENT_PROT_READ_CMD: begin // RULE_10
				c.addr_bits = ADDR_BITS;
				c.dout_bits = BYTE_BITS;
			end
			PERSISTENT_PROT_PROGRAM_CMD: c.addr_bits = ADDR_BITS; // RULE_11
			PASSWORD_READ_CMD: begin // RULE_12
				c.zero_addr = 1'b1;
				c.addr_bits = ADDR_BITS;
				c.dummy_bits = PASS_DUMMY_BITS;
				c.dout_bits = PASS_BITS;
			end
			PASSWORD_WRITE_CMD, PASSWORD_UNLOCK_CMD: begin // RULE_13
				c.zero_addr = 1'b1;
				c.addr_bits = ADDR_BITS;
				c.din_bits = PASS_BITS;
			end
			WAKE_FROM_POWERDOWN_CMD: c.valid = 1'b1; // RULE_14
			RESET_ARM_CMD, MEM_RESET_CMD: c.valid = 1'b1;
			default: c.valid = 1'b0;
		endcase
		return c;
	endfunction

endpackage

// ### shared/scd_if.sv
`timescale 1ns/10ps
interface scd_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso;

	// Released output floats high
	assign miso = miso_oe ? miso_o : 1'b1;

	modport device (input cs_n, input sclk, input mosi, output miso_o,
		output miso_oe);
	modport host (output cs_n, output sclk, output mosi, input miso);
endinterface

// ### logic/scd_sync.sv
`timescale 1ns/10ps
module scd_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule // scd_sync

// ### logic/scd_host.sv
`timescale 1ns/10ps
module scd_host (
	input wire logic core_clk,
	input wire logic rst,
	scd_if.host lnk,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_op,
	input wire logic [31:0] req_addr,
	input wire logic [63:0] req_wdata,
	input wire logic [3:0] req_rd_bytes,
	output logic rsp_valid,
	output logic rsp_bad,
	output logic [63:0] rsp_rdata
);
	import scd_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE, H_SETUP, H_HIGH, H_LOW, H_END, H_GAP
	} scd_hst_t;

	scd_hst_t st_ff, nxt_st;
	logic [2:0] div_ff, nxt_div;
	logic [6:0] bit_ff, nxt_bit;
	logic [6:0] total_ff, nxt_total;
	logic [6:0] wend_ff, nxt_wend;
	logic [7:0] op_ff, nxt_op;
	logic [31:0] addr_ff, nxt_addr;
	logic [63:0] wdata_ff, nxt_wdata;
	logic [63:0] rx_ff, nxt_rx;
	scd_cmd_t ci_ff, nxt_ci, ci_req;
	logic armed_ff, nxt_armed;
	logic cs_n_ff, nxt_cs_n;
	logic sclk_ff, nxt_sclk;
	logic mosi_ff, nxt_mosi;
	logic ready_ff, nxt_ready;
	logic rv_ff, nxt_rv;
	logic bad_ff, nxt_bad;
	logic [63:0] rdata_ff, nxt_rdata;
	logic miso_s;
	logic half_end;
	logic [6:0] rd_bits;

	scd_sync #(.W(1)) u_miso_sync (
		.clk(core_clk),
		.rst(rst),
		.d(lnk.miso),
		.q(miso_s)
	);

	function automatic logic out_bit(input logic [6:0] b,
		input logic [7:0] op, input logic [31:0] a, input logic [63:0] w,
		input scd_cmd_t c, input logic [6:0] wend);
		logic [6:0] a_end;
		logic [6:0] d_end;
		a_end = OPCODE_BITS + c.addr_bits;
		d_end = a_end + c.dummy_bits;
		if (b < OPCODE_BITS)
			return op[3'(7'd7 - b)];
		if (b < a_end)
			return a[5'(7'd39 - b)];
		if (b < d_end || b >= wend)
			return 1'b0;
		return w[6'(wend - 7'd1 - b)];
	endfunction

	// ----------------------------------------
	// Frame sequencer and clock divider
	// ----------------------------------------
	always_comb begin
		half_end = (div_ff == SCLK_HALF_CYC - 3'd1);
		ci_req = scd_cmd_info(req_op);
		rd_bits = {req_rd_bytes, 3'b000};
		nxt_st = st_ff;
		nxt_div = half_end ? 3'd0 : div_ff + 3'd1;
		nxt_bit = bit_ff;
		nxt_total = total_ff;
		nxt_wend = wend_ff;
		nxt_op = op_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_rx = rx_ff;
		nxt_ci = ci_ff;
		nxt_armed = armed_ff;
		nxt_cs_n = cs_n_ff;
		nxt_sclk = sclk_ff;
		nxt_mosi = mosi_ff;
		nxt_ready = ready_ff;
		nxt_rv = 1'b0;
		nxt_bad = bad_ff;
		nxt_rdata = rdata_ff;
		case (st_ff)
			H_IDLE: begin
				nxt_div = 3'd0;
				if (req_valid && ready_ff) begin
					if (!ci_req.valid || (req_op == MEM_RESET_CMD &&
						!armed_ff)) begin // RULE_15 RULE_17
						nxt_rv = 1'b1;
						nxt_bad = 1'b1;
					end else begin
						nxt_ci = ci_req;
						if (rd_bits != 7'd0 && rd_bits < ci_req.dout_bits)
							nxt_ci.dout_bits = rd_bits; // RULE_07
						nxt_op = req_op;
						nxt_addr = ci_req.zero_addr ? 32'h0 : req_addr; // RULE_17
						nxt_wdata = req_wdata;
						nxt_wend = OPCODE_BITS + ci_req.addr_bits +
							ci_req.dummy_bits + ci_req.din_bits;
						nxt_total = nxt_wend + nxt_ci.dout_bits;
						nxt_bit = 7'd0;
						nxt_rx = 64'h0;
						nxt_cs_n = 1'b0;
						nxt_mosi = req_op[7]; // RULE_20
						nxt_ready = 1'b0;
						nxt_st = H_SETUP;
					end
				end
			end
			H_SETUP, H_LOW: begin
				if (half_end) begin
					nxt_sclk = 1'b1;
					if (bit_ff >= wend_ff)
						nxt_rx = {rx_ff[62:0], miso_s};
					nxt_st = H_HIGH;
				end
			end
			H_HIGH: begin
				if (half_end) begin
					nxt_sclk = 1'b0;
					if (bit_ff == total_ff - 7'd1) begin
						nxt_mosi = 1'b0;
						nxt_st = H_END;
					end else begin
						nxt_bit = bit_ff + 7'd1; // RULE_20
						nxt_mosi = out_bit(nxt_bit, op_ff, addr_ff, wdata_ff,
							ci_ff, wend_ff);
						nxt_st = H_LOW;
					end
				end
			end
			H_END: begin
				if (half_end) begin
					nxt_cs_n = 1'b1;
					nxt_st = H_GAP;
				end
			end
			H_GAP: begin
				if (half_end) begin
					nxt_rv = 1'b1;
					nxt_bad = 1'b0;
					nxt_rdata = rx_ff;
					nxt_armed = (op_ff == RESET_ARM_CMD); // RULE_15
					nxt_ready = 1'b1;
					nxt_st = H_IDLE;
				end
			end
			default: nxt_st = H_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_ff <= H_IDLE;
			div_ff <= 3'd0;
			bit_ff <= 7'd0;
			total_ff <= 7'd0;
			wend_ff <= 7'd0;
			op_ff <= 8'h00;
			addr_ff <= 32'h0;
			wdata_ff <= 64'h0;
			rx_ff <= 64'h0;
			ci_ff <= '0;
			armed_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			sclk_ff <= 1'b0;
			mosi_ff <= 1'b0;
			ready_ff <= 1'b1;
			rv_ff <= 1'b0;
			bad_ff <= 1'b0;
			rdata_ff <= 64'h0;
		end else begin
			st_ff <= nxt_st;
			div_ff <= nxt_div;
			bit_ff <= nxt_bit;
			total_ff <= nxt_total;
			wend_ff <= nxt_wend;
			op_ff <= nxt_op;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			rx_ff <= nxt_rx;
			ci_ff <= nxt_ci;
			armed_ff <= nxt_armed;
			cs_n_ff <= nxt_cs_n;
			sclk_ff <= nxt_sclk;
			mosi_ff <= nxt_mosi;
			ready_ff <= nxt_ready;
			rv_ff <= nxt_rv;
			bad_ff <= nxt_bad;
			rdata_ff <= nxt_rdata;
		end
	end

	assign lnk.cs_n = cs_n_ff;
	assign lnk.sclk = sclk_ff;
	assign lnk.mosi = mosi_ff;
	assign req_ready = ready_ff;
	assign rsp_valid = rv_ff;
	assign rsp_bad = bad_ff;
	assign rsp_rdata = rdata_ff;
endmodule // scd_host

// ### verification/scd_checker.sv
`timescale 1ns/10ps
module scd_checker
	import scd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe,
	input wire logic miso
);
	// ----------------------------------------
	// Frame bit counter and opcode capture
	// ----------------------------------------
	logic [6:0] cnt_ff, nxt_cnt;
	logic [7:0] op_ff, nxt_op;
	logic rd_op, any_rd;

	always_comb begin
		nxt_cnt = cnt_ff + {6'h00, cnt_ff != 7'h7f};
		nxt_op = (cnt_ff < 7'h08) ? {op_ff[6:0], mosi} : op_ff;
		rd_op = op_ff inside {8'h05, 8'h15, 8'h2b, 8'h16};
		any_rd = rd_op || (op_ff inside {8'h71, 8'he2, 8'h27});
	end

	always_ff @(posedge sclk or posedge rst or posedge cs_n) begin
		if (rst || cs_n) begin
			cnt_ff <= 7'h00;
			op_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
			op_ff <= nxt_op;
		end
	end

	// ----------------------------------------
	// Link checks
	// ----------------------------------------
	a_no_early_drive: assert property (@(posedge sclk)
		disable iff (rst) cnt_ff < 7'h08 |-> !miso_oe)
		else $error("output during opcode");
	a_first_out_bit: assert property (@(posedge sclk)
		disable iff (rst) cnt_ff == 7'h08 && rd_op |-> miso_oe)
		else $error("read data late");
	a_addr_read_out: assert property (@(posedge sclk)
		disable iff (rst)
		cnt_ff == 7'h28 && op_ff inside {8'h71, 8'he2} |-> miso_oe)
		else $error("read after address late");
	a_pass_dummy: assert property (@(posedge sclk) disable iff (rst)
		op_ff == 8'h27 && cnt_ff < 7'h30 |-> !miso_oe)
		else $error("password data before dummy end");
	a_silent_ops: assert property (@(posedge sclk)
		disable iff (rst) cnt_ff >= 7'h08 && !any_rd |-> !miso_oe)
		else $error("output driven for non-read");
	a_idle_released: assert property (@(posedge core_clk)
		disable iff (rst) cs_n |-> !miso_oe && miso)
		else $error("output not released");
	a_sclk_idle: assert property (@(posedge core_clk) disable iff (rst)
		cs_n |-> !sclk) else $error("clock outside frame");
	a_frame_lead: assert property (@(posedge core_clk)
		disable iff (rst) $fell(cs_n) |-> !sclk [*4] ##1 sclk)
		else $error("frame start wrong");
	a_sclk_half: assert property (@(posedge core_clk) disable iff (rst)
		$rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("clock high time");
	a_mosi_hold: assert property (@(posedge core_clk) disable iff (rst)
		sclk && $past(sclk) |-> $stable(mosi)) else $error("data moved high");
	a_miso_on_fall: assert property (@(posedge core_clk)
		disable iff (rst) !cs_n && !$past(cs_n) && $changed(miso)
		|-> $fell(sclk)) else $error("output moved off falling edge");
endmodule // scd_checker

// ### verification/tb_single_line_command_decoder.sv
`timescale 1ns/10ps
module tb_single_line_command_decoder;
	import scd_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b0;
	logic req_valid = 1'b0;
	logic [7:0] req_op = 8'h00;
	logic [31:0] req_addr = 32'h0;
	logic [63:0] req_wdata = 64'h0;
	logic [3:0] req_rd_bytes = 4'h0;
	logic req_ready, rsp_valid, rsp_bad, mem_p, wake_p, mem_p2;
	logic [63:0] rsp_rdata, got;
	logic [7:0] cfg2 [4] = '{default: 8'h00};
	logic [7:0] spb = 8'h00;
	logic [7:0] sec = 8'h00;
	logic [7:0] last_op = 8'h00;
	logic [31:0] fbr = 32'hffff_ffff;
	logic [63:0] pass = '1;
	logic [7:0] ops [15] = '{8'h05, 8'h15, 8'h2b, 8'h16, 8'h27, 8'h71,
		8'he2, 8'h72, 8'h2f, 8'h17, 8'h18, 8'he3, 8'h28, 8'h29, 8'hab};
	int failures = 0;
	int tests_run = 0;
	int mem_cnt = 0, wake_cnt = 0, mem2_cnt = 0, exp_mem = 0, exp_wake = 0;

	scd_if lnk_if();
	scd_if bad_if();

	scd_host scd_host_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
		.req_addr(req_addr), .req_wdata(req_wdata),
		.req_rd_bytes(req_rd_bytes), .rsp_valid(rsp_valid),
		.rsp_bad(rsp_bad), .rsp_rdata(rsp_rdata));
	scd_device scd_device_inst (.core_clk(core_clk), .rst(rst),
		.lnk(lnk_if), .mem_reset_pulse(mem_p), .wake_pulse(wake_p));
	scd_device bad_scd_device_inst (.core_clk(core_clk), .rst(rst),
		.lnk(bad_if), .mem_reset_pulse(mem_p2), .wake_pulse());
	scd_checker scd_checker_inst (.core_clk(core_clk), .rst(rst),
		.cs_n(lnk_if.cs_n), .sclk(lnk_if.sclk), .mosi(lnk_if.mosi),
		.miso_o(lnk_if.miso_o), .miso_oe(lnk_if.miso_oe),
		.miso(lnk_if.miso));

	always #25 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		mem_cnt += int'(mem_p === 1'b1);
		wake_cnt += int'(wake_p === 1'b1);
		mem2_cnt += int'(mem_p2 === 1'b1);
	end

	task automatic check(input string name, input logic [63:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Expected frame length and register model
	// ----------------------------------------
	function automatic int exp_bits(input logic [7:0] op, logic [3:0] rb);
		case (op)
			8'h05, 8'h15, 8'h2b: return 16;
			8'h2f, 8'h18, 8'hab, 8'h66, 8'h99: return 8;
			8'h71, 8'h72, 8'he2: return 48;
			8'h16: return 8 + 8 * ((rb == 4'h0) ? 4 : int'(rb));
			8'h17, 8'he3: return 40;
			8'h27: return 112;
			8'h28, 8'h29: return 104;
			default: return 0;
		endcase
	endfunction

	function automatic logic [63:0] model(input logic [7:0] op,
		logic [31:0] a, logic [63:0] w, logic [3:0] rb);
		logic [63:0] e;
		e = 64'h0;
		case (op)
			8'h2b: e = {56'h0, sec};
			8'h71: e = {56'h0, cfg2[a[1:0]]};
			8'he2: e = {56'h0, {8{spb[a[2:0]]}}};
			8'h16: e = {32'h0, fbr >> (8 * (4 - ((rb == 0) ? 4 : rb)))};
			8'h27: e = pass;
			8'h72: cfg2[a[1:0]] = w[7:0];
			8'h2f: sec[1] = 1'b1;
			8'h17: fbr = w[31:0];
			8'h18: fbr = 32'hffff_ffff;
			8'he3: spb[a[2:0]] = 1'b1;
			8'h28: pass = w;
			8'h29: sec[7] = (w == pass);
			8'hab: exp_wake++;
			8'h99: exp_mem++;
			default: e = 64'h0;
		endcase
		return e;
	endfunction

	task automatic req(input logic [7:0] op, logic [31:0] a,
		logic [63:0] w, logic [3:0] rb);
		int n;
		int bits;
		logic [63:0] e;
		bits = exp_bits(op, rb);
		if (op == 8'h99 && last_op != 8'h66)
			bits = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_addr <= a;
		req_wdata <= w;
		req_rd_bytes <= rb;
		@(negedge core_clk);
		check("ready", req_ready, 1);
		@(posedge core_clk);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 1000);
		check("latency", n, (bits > 0) ? 8 * bits + 9 : 1);
		check("refused", rsp_bad, bits == 0);
		if (bits > 0) begin
			last_op = op;
			e = model(op, a, w, rb);
		end
		if (bits > 0 && op inside {8'h05, 8'h15, 8'h2b, 8'h16, 8'h27,
			8'h71, 8'he2})
			check(name_of(op), rsp_rdata, e);
	endtask

	function automatic string name_of(input logic [7:0] op);
		return $sformatf("read %h", op);
	endfunction

	// Bench-made link clock, 12 ns, still between frames
	task automatic bb(input logic [127:0] v, input int n);
		bad_if.cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			bad_if.mosi = v[i];
			#3 got = {got[62:0], bad_if.miso};
			bad_if.sclk = 1'b1;
			#6 bad_if.sclk = 1'b0;
			#3;
		end
		bad_if.cs_n = 1'b1;
		bad_if.mosi = ~bad_if.mosi;
		repeat (10) @(posedge core_clk);
	endtask

	initial begin
		logic [7:0] op;
		bad_if.cs_n = 1'b1;
		bad_if.sclk = 1'b0;
		bad_if.mosi = 1'b0;
		rst <= 1'b1;
		void'($urandom(10));
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		foreach (ops[i])
			req(ops[i], i, 64'h0, 4'h0);
		req(8'h00, 0, 0, 0);
		req(8'h28, 0, 64'h0123_4567_89ab_cdef, 0);
		req(8'h29, 0, 64'h0123_4567_89ab_cdef, 0);
		req(8'h2b, 0, 0, 0);
		req(8'h16, 0, 0, 4'h1);
		repeat (40) begin
			op = ops[$urandom_range(14)];
			req(op, $urandom, {$urandom, $urandom},
				(op == 8'h16) ? 4'($urandom_range(4)) : 4'h0);
		end
		req(8'h05, 0, 0, 0);
		req(8'h99, 0, 0, 0);
		req(8'h66, 0, 0, 0);
		req(8'h99, 0, 0, 0);
		repeat (10) @(posedge core_clk);
		check("mem resets", mem_cnt, exp_mem);
		check("wakes", wake_cnt, exp_wake);
		bb({8'h00, 16'h0}, 24);
		check("bad opcode out", got[23:0], 24'hff_ffff);
		bb({8'h28, 96'h0}, 104);
		bb({8'h27, 104'h0}, 112);
		check("password", got, 64'h0);
		bb({8'h27, 32'h1, 72'h0}, 112);
		check("bad address out", got, '1);
		bb({8'h17, 32'h1234_5678}, 40);
		bb({8'h17, 16'h0}, 24);
		bb({8'h16, 32'h0}, 40);
		check("fast-boot kept", got[31:0], 32'h1234_5678);
		bb(8'h66, 8);
		bb({8'h05, 8'h0}, 16);
		bb(8'h99, 8);
		check("reset ignored", mem2_cnt, 0);
		bb(8'h66, 8);
		bb(8'h99, 8);
		check("reset taken", mem2_cnt, 1);
		summarize();
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		failures++;
		summarize();
	end
endmodule // tb_single_line_command_decoder
